// >>> pkg/sba_pkg.sv
// package: constants for the serial baud select and address match block
package sba_pkg;
	// ****************************************************************
	// register map (word offsets, not byte addresses)
	// ****************************************************************
	localparam logic [3:0] ADDR_SADR = 4'h0;   // slave_address_reg
	localparam logic [3:0] ADDR_SMSK = 4'h1;   // slave_address_mask_reg
	localparam logic [3:0] ADDR_CTRL = 4'h2;   // serial control
	localparam logic [3:0] ADDR_T2CN = 4'h3;   // t2_control_reg
	localparam logic [3:0] ADDR_T2RL = 4'h4;   // t2 reload pair
	localparam logic [3:0] ADDR_T2CT = 4'h5;   // t2 count pair
	localparam logic [3:0] ADDR_T1OV = 4'h6;   // not decoded by the block, reads return zero
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_MODE_LO = 0;  // serial mode, 2 bits
	localparam int CTRL_DBL = 2;      // baud_doubler_bit
	localparam int CTRL_MPE = 3;      // multiproc_enable
	localparam int CTRL_DONE = 4;     // receive_done_flag, write zero clears
	localparam int T2_RUN = 0;        // t2_run_bit
	localparam int T2_CTR = 1;        // t2_counter_select
	localparam int T2_RXSEL = 2;      // rx_clock_select
	localparam int T2_TXSEL = 3;      // tx_clock_select
	localparam int T2_EXEN = 4;       // t2_external_enable
	localparam int T2_EXF = 5;        // t2_external_flag
	localparam int T2_OVF = 6;        // t2_overflow_flag
	// ****************************************************************
	// reset values and divider figures
	// ****************************************************************
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] MODE0_DIV = 8'h0c;    // fosc / 12
	localparam logic [7:0] MODE2_DIV = 8'h40;    // fosc / 64
	localparam logic [7:0] T1_DIV = 8'h20;       // t1 overflow / 32
	localparam logic [7:0] T2_DIV = 8'h10;       // t2 overflow / 16
	localparam logic [7:0] STATE_DIV = 8'h02;    // one state time = 2 fosc
	localparam logic [15:0] T2_TOP = 16'hffff;   // timer 2 count just before rollover
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	// serial modes
	typedef enum logic [1:0] {
		SBA_SHIFT = 2'b00,
		SBA_ASYNC8 = 2'b01,
		SBA_FIXED9 = 2'b10,
		SBA_TIMED9 = 2'b11
	} sba_mode_e;
endpackage

// >>> rtl/sba_rate_div.sv
// module: one direction's rate tick divider
`timescale 1ns/1ps
`default_nettype none
module sba_rate_div (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// source tick and divide ratio
	input wire logic i_src,
	input wire logic [7:0] i_div,
	// output tick
	output logic o_tick
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] cnt;  // source pulses seen
		logic tick;       // registered rate tick
	} sba_div_s;
	sba_div_s st_r;
	sba_div_s st_nxt;

	// count source pulses, tick once per ratio
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (i_src) begin
			// wrap at ratio minus one
			if (st_r.cnt >= i_div - 8'h01) begin
				st_nxt.cnt = 8'h00;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
	end

	// register state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_tick = st_r.tick;
endmodule // sba_rate_div
`default_nettype wire

// >>> rtl/sba_top.sv
// module: serial baud select, timer 2 baud generator and address match
// Function
// RULE_01 - broadcast address is address OR mask
// RULE_02 - reset clears address and mask to zero
// RULE_03 - shift mode rate is oscillator over twelve
// RULE_04 - fixed nine-bit mode: fosc/64, doubler doubles
// RULE_05 - timer 1 default source, overflow/32, doubled
// RULE_06 - independent transmit and receive rate clocks
// RULE_07 - software sets timer 1 auto-reload mode
// RULE_08 - software reloads 16-bit timer for slow rates
// RULE_09 - software disables timer 1 interrupt, picks mode
// RULE_10 - clock select bits pick timer 2 or 1
// RULE_11 - high byte rollover reloads both count bytes
// RULE_12 - timer 2 rate is overflow over sixteen
// RULE_13 - select bits force baud mode, no overflow flag
// RULE_14 - external edge sets flag, no reload
// RULE_15 - timer 2 counts every two oscillator periods
// RULE_16 - software stops timer 2 before access
// RULE_17 - software avoids count and reload writes running
// RULE_18 - software picks timer or counter operation
// RULE_19 - given address masks don't-care bits
// RULE_20 - multiproc mode drops data frames, flags matches
// RULE_21 - ten-bit mode uses stop bit as ninth
// RULE_22 - match given or broadcast address
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sba_top (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// timer 1 overflow pulse and timer 2 pins
	input wire logic i_t1_overflow,
	input wire logic i_t2_count_pin,
	input wire logic i_t2_external_input,
	// received frame from the shifter
	input wire logic i_rx_frame_done,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_bit9,
	input wire logic i_rx_stop_ok,
	// outputs
	output logic o_tx_tick,
	output logic o_rx_tick,
	output logic o_receive_done_flag,
	output logic o_t2_ext_irq
);
	// ****************************************************************
	// reset synchroniser
	// ****************************************************************
	logic rst_meta_r;
	logic rst_n_r;
	// release through two flops; meta flop feeds only the second one
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] slave_address_reg;     // slave_address_reg
		logic [7:0] smask;     // slave_address_mask_reg
		logic [1:0] mode;      // serial mode
		logic dbl;             // baud_doubler_bit
		logic mpe;             // multiproc_enable
		logic run;             // t2_run_bit
		logic ctr;             // t2_counter_select
		logic rxsel;           // rx_clock_select
		logic txsel;           // tx_clock_select
		logic exen;            // t2_external_enable
		logic exf;             // t2_external_flag
		logic ovf;             // t2_overflow_flag
		logic [15:0] reload;   // t2_reload_high/low
		logic [15:0] count;    // t2_count_high/low
		logic state_ph;        // state time phase
		logic pin_d;           // count pin delayed
		logic ext_d;           // external input delayed
		logic t2_ovp;          // timer 2 overflow pulse
		logic rdone;           // receive_done_flag
		logic [31:0] rdata;    // bus read data
		logic wait_n;          // answer phase
	} sba_st_s;
	sba_st_s st_r;
	sba_st_s st_nxt;

	// ****************************************************************
	// rate sources
	// ****************************************************************
	logic t2_inc;       // timer 2 increment this cycle
	logic st_tick;      // one state time elapsed
	logic fosc_tick;    // every oscillator cycle
	logic tx_src;
	logic rx_src;
	logic [7:0] tx_div;
	logic [7:0] rx_div;
	logic [7:0] t1_ratio;
	logic [7:0] m2_ratio;
	logic tx_tick_w;
	logic rx_tick_w;
	logic [7:0] given_care;
	logic given_hit;
	logic bcast_hit;
	logic [7:0] bcast_addr;
	logic acc;

	assign fosc_tick = 1'b1;
	// RULE_15 state time tick
	assign st_tick = st_r.state_ph;
	// RULE_18 timer or counter source
	assign t2_inc = st_r.run & (st_r.ctr ? (st_r.pin_d & ~i_t2_count_pin) : st_tick);
	// RULE_05 doubler halves ratio
	assign t1_ratio = st_r.dbl ? (sba_pkg::T1_DIV >> 1) : sba_pkg::T1_DIV;
	// RULE_04 mode 2 ratio
	assign m2_ratio = st_r.dbl ? (sba_pkg::MODE2_DIV >> 1) : sba_pkg::MODE2_DIV;

	// pick sources per direction
	always_comb begin
		tx_src = i_t1_overflow;
		rx_src = i_t1_overflow;
		tx_div = t1_ratio;
		rx_div = t1_ratio;
		case (sba_pkg::sba_mode_e'(st_r.mode))
			// RULE_03 fixed shift rate
			sba_pkg::SBA_SHIFT: begin
				tx_src = fosc_tick;
				rx_src = fosc_tick;
				tx_div = sba_pkg::MODE0_DIV;
				rx_div = sba_pkg::MODE0_DIV;
			end
			sba_pkg::SBA_FIXED9: begin
				tx_src = fosc_tick;
				rx_src = fosc_tick;
				tx_div = m2_ratio;
				rx_div = m2_ratio;
			end
			sba_pkg::SBA_ASYNC8, sba_pkg::SBA_TIMED9: begin
				// RULE_10 per-direction timer choice
				if (st_r.txsel) begin
					tx_src = st_r.t2_ovp;
					// RULE_12 timer 2 over sixteen
					tx_div = sba_pkg::T2_DIV;
				end
				if (st_r.rxsel) begin
					rx_src = st_r.t2_ovp;
					rx_div = sba_pkg::T2_DIV;
				end
			end
			default: begin
				tx_src = 1'b0;
				rx_src = 1'b0;
			end
		endcase
	end

	// RULE_06 independent dividers
	sba_rate_div u_tx_div (
		.i_clk(i_clk),
		.i_rst_n(rst_n_r),
		.i_src(tx_src),
		.i_div(tx_div),
		.o_tick(tx_tick_w)
	);
	sba_rate_div u_rx_div (
		.i_clk(i_clk),
		.i_rst_n(rst_n_r),
		.i_src(rx_src),
		.i_div(rx_div),
		.o_tick(rx_tick_w)
	);

	// ****************************************************************
	// address recognition
	// ****************************************************************
	// RULE_19 given address care bits
	assign given_care = st_r.smask;
	assign given_hit = ((i_rx_byte ^ st_r.slave_address_reg) & given_care) == 8'h00;
	// RULE_01 broadcast is or of address and mask
	assign bcast_addr = st_r.slave_address_reg | st_r.smask;
	// zeros of the broadcast are don't-care, so only its ones must match
	assign bcast_hit = ((~i_rx_byte) & bcast_addr) == 8'h00;
	assign acc = i_avs_read | i_avs_write;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.state_ph = ~st_r.state_ph;
		st_nxt.pin_d = i_t2_count_pin;
		st_nxt.ext_d = i_t2_external_input;
		st_nxt.t2_ovp = 1'b0;
		// timer 2 counting
		if (t2_inc) begin
			if (st_r.count == sba_pkg::T2_TOP) begin
				// RULE_11 reload both bytes
				st_nxt.count = st_r.reload;
				if (st_r.rxsel | st_r.txsel) begin
					st_nxt.t2_ovp = 1'b1;
				end else begin
					// RULE_13 overflow flag only outside baud mode
					st_nxt.ovf = 1'b1;
				end
			end else begin
				st_nxt.count = st_r.count + 16'h0001;
			end
		end
		// bus: one wait cycle, answer on the second
		st_nxt.wait_n = acc & ~st_r.wait_n;
		if (acc && !st_r.wait_n) begin
			st_nxt.rdata = sba_pkg::RD_UNMAPPED;
			if (i_avs_read) begin
				case (i_avs_address)
					sba_pkg::ADDR_SADR: st_nxt.rdata = {24'h000000, st_r.slave_address_reg};
					sba_pkg::ADDR_SMSK: st_nxt.rdata = {24'h000000, st_r.smask};
					sba_pkg::ADDR_CTRL: st_nxt.rdata = {27'h0, st_r.rdone, st_r.mpe,
						st_r.dbl, st_r.mode};
					sba_pkg::ADDR_T2CN: st_nxt.rdata = {25'h0, st_r.ovf, st_r.exf, st_r.exen,
						st_r.txsel, st_r.rxsel, st_r.ctr, st_r.run};
					sba_pkg::ADDR_T2RL: st_nxt.rdata = {16'h0000, st_r.reload};
					sba_pkg::ADDR_T2CT: st_nxt.rdata = {16'h0000, st_r.count};
					default: st_nxt.rdata = sba_pkg::RD_UNMAPPED;
				endcase
			end
		end
		// a write lands only at the edge where the master sees waitrequest low
		if (i_avs_write && st_r.wait_n) begin
			case (i_avs_address)
				sba_pkg::ADDR_SADR: st_nxt.slave_address_reg = i_avs_writedata[7:0];
				sba_pkg::ADDR_SMSK: st_nxt.smask = i_avs_writedata[7:0];
				sba_pkg::ADDR_CTRL: begin
					st_nxt.mode = i_avs_writedata[sba_pkg::CTRL_MODE_LO +: 2];
					st_nxt.dbl = i_avs_writedata[sba_pkg::CTRL_DBL];
					st_nxt.mpe = i_avs_writedata[sba_pkg::CTRL_MPE];
					// writing zero to the done bit clears the flag
					if (!i_avs_writedata[sba_pkg::CTRL_DONE]) begin
						st_nxt.rdone = 1'b0;
					end
				end
				sba_pkg::ADDR_T2CN: begin
					st_nxt.run = i_avs_writedata[sba_pkg::T2_RUN];
					st_nxt.ctr = i_avs_writedata[sba_pkg::T2_CTR];
					st_nxt.rxsel = i_avs_writedata[sba_pkg::T2_RXSEL];
					st_nxt.txsel = i_avs_writedata[sba_pkg::T2_TXSEL];
					st_nxt.exen = i_avs_writedata[sba_pkg::T2_EXEN];
					// flags clear by writing zero
					if (!i_avs_writedata[sba_pkg::T2_EXF]) begin
						st_nxt.exf = 1'b0;
					end
					if (!i_avs_writedata[sba_pkg::T2_OVF]) begin
						st_nxt.ovf = 1'b0;
					end
				end
				// RULE_16 software stops timer first; no guard here
				sba_pkg::ADDR_T2RL: st_nxt.reload = i_avs_writedata[15:0];
				sba_pkg::ADDR_T2CT: st_nxt.count = i_avs_writedata[15:0];
				default: st_nxt.rdone = st_r.rdone;
			endcase
		end
		// hardware sets after software clears: set wins
		if (t2_inc && st_r.count == sba_pkg::T2_TOP && !(st_r.rxsel | st_r.txsel)) begin
			st_nxt.ovf = 1'b1;
		end
		// RULE_14 external edge sets flag, never reloads
		if (st_r.ext_d && !i_t2_external_input) begin
			st_nxt.exf = 1'b1;
		end
		// frame acceptance
		if (i_rx_frame_done) begin
			if (!st_r.mpe || st_r.mode == sba_pkg::SBA_SHIFT) begin
				st_nxt.rdone = 1'b1;
			end else if (st_r.mode == sba_pkg::SBA_ASYNC8) begin
				// RULE_21 stop bit acts as ninth
				if (i_rx_stop_ok && (given_hit || bcast_hit)) begin
					st_nxt.rdone = 1'b1;
				end
			// RULE_20 drop data frames
			end else if (i_rx_bit9) begin
				// RULE_22 given or broadcast match
				if (given_hit || bcast_hit) begin
					st_nxt.rdone = 1'b1;
				end
			end
		end
	end

	// register state
	always_ff @(posedge i_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= '0;
			// RULE_02 addresses cleared
			st_r.slave_address_reg <= sba_pkg::ADDR_RST;
			st_r.smask <= sba_pkg::ADDR_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// registered outputs
	always_ff @(posedge i_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_tx_tick <= 1'b0;
			o_rx_tick <= 1'b0;
			o_receive_done_flag <= 1'b0;
			o_t2_ext_irq <= 1'b0;
			o_avs_readdata <= sba_pkg::RD_UNMAPPED;
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_tx_tick <= tx_tick_w;
			o_rx_tick <= rx_tick_w;
			o_receive_done_flag <= st_nxt.rdone;
			o_t2_ext_irq <= st_nxt.exf & st_nxt.exen;
			o_avs_readdata <= st_nxt.rdata;
			o_avs_waitrequest <= ~st_nxt.wait_n;
		end
	end
endmodule // sba_top
`default_nettype wire

// >>> testbench/sba_node.sv
// model of the other serial nodes that hand received frames to the block
`timescale 1ns/1ps
`default_nettype none
module sba_node (
	// clock
	input wire logic i_clk,
	// frame as the shifter presents it
	output logic o_done,
	output logic [7:0] o_byte,
	output logic o_bit9,
	output logic o_stop
);
	// outside a frame the lines show the inverse of the last value, never a stale copy
	initial begin
		o_done = 1'b0;
		o_byte = 8'h5a;
		o_bit9 = 1'b0;
		o_stop = 1'b1;
	end
	// one frame: fields valid only with the done pulse
	task automatic send(input logic [7:0] b, input logic n9, input logic st);
		@(posedge i_clk);
		o_done <= 1'b1;
		o_byte <= b;
		o_bit9 <= n9;
		o_stop <= st;
		@(posedge i_clk);
		o_done <= 1'b0;
		o_byte <= ~b;
		o_bit9 <= ~n9;
		o_stop <= ~st;
	endtask
endmodule // sba_node
`default_nettype wire

// >>> testbench/sba_checker.sv
// checker: port-level assertions for the baud select and address match block
`timescale 1ns/1ps
`default_nettype none
module sba_checker (
	// clock, reset and bus
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// frames and rate ticks
	input wire logic i_rx_frame_done,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_bit9,
	input wire logic i_rx_stop_ok,
	input wire logic o_tx_tick,
	input wire logic o_rx_tick,
	input wire logic o_receive_done_flag
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// shadows of written registers; gaps count clocks since the previous tick
	logic [7:0] ad_r, mk_r;
	logic [3:0] ctl_r, t2c_r;
	logic [15:0] rl_r, txg_r, rxg_r;
	logic [1:0] txq_r, rxq_r;
	logic wt, en, ok;
	assign wt = i_avs_write && !o_avs_waitrequest;
	assign en = ctl_r[3] && ctl_r[1:0] != 2'b00;
	assign ok = ctl_r[1] ? i_rx_bit9 : i_rx_stop_ok;
	// only intervals that start after the last write are judged, old divider phase is junk
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			{ad_r, mk_r, ctl_r, t2c_r, rl_r} <= '0;
			{txg_r, rxg_r, txq_r, rxq_r} <= '0;
		end else begin
			if (wt && i_avs_address == sba_pkg::ADDR_SADR) ad_r <= i_avs_writedata[7:0];
			if (wt && i_avs_address == sba_pkg::ADDR_SMSK) mk_r <= i_avs_writedata[7:0];
			if (wt && i_avs_address == sba_pkg::ADDR_CTRL) ctl_r <= i_avs_writedata[3:0];
			if (wt && i_avs_address == sba_pkg::ADDR_T2CN) t2c_r <= i_avs_writedata[3:0];
			if (wt && i_avs_address == sba_pkg::ADDR_T2RL) rl_r <= i_avs_writedata[15:0];
			txg_r <= o_tx_tick ? 16'h0001 : txg_r + 16'h0001;
			rxg_r <= o_rx_tick ? 16'h0001 : rxg_r + 16'h0001;
			txq_r <= wt ? 2'h0 : txq_r + {1'b0, o_tx_tick && txq_r != 2'h3};
			rxq_r <= wt ? 2'h0 : rxq_r + {1'b0, o_rx_tick && rxq_r != 2'h3};
		end
	end
	// given or broadcast address hit, zeros of the mask are don't-care
	function automatic logic hit(input logic [7:0] r);
		return (((r ^ ad_r) & mk_r) == 8'h00) || ((r & (ad_r | mk_r)) == (ad_r | mk_r));
	endfunction
	a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_answer_next: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
		else $error("bus answer late");
	a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address > sba_pkg::ADDR_T2CT |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_shift_rate: assert property (o_tx_tick && ctl_r[1:0] == 2'b00 && txq_r == 2'h3
		|-> txg_r == 16'h000c) else $error("shift mode rate wrong");
	a_fixed_rate: assert property (o_rx_tick && ctl_r[1:0] == 2'b10 && rxq_r == 2'h3
		|-> rxg_r == (ctl_r[2] ? 16'h0020 : 16'h0040)) else $error("fixed rate wrong");
	a_t2_rate: assert property (o_rx_tick && ctl_r[0] && rxq_r == 2'h3 && t2c_r[2:0] == 3'b101
		&& rl_r[15:8] == 8'hff |-> rxg_r == ((16'hffff - rl_r + 16'h0001) << 5))
		else $error("timer 2 rate wrong");
	a_flag_hold: assert property (o_receive_done_flag
		&& !(i_avs_write && i_avs_address == sba_pkg::ADDR_CTRL) |=> o_receive_done_flag)
		else $error("receive flag dropped");
	a_match_sets: assert property (i_rx_frame_done && en && ok && hit(i_rx_byte)
		|-> ##[1:3] o_receive_done_flag) else $error("matching frame not flagged");
	a_frame_ignored: assert property (i_rx_frame_done && en && !(ok && hit(i_rx_byte))
		&& !o_receive_done_flag |=> !o_receive_done_flag [*3]) else $error("frame not ignored");
	// main scenarios reached
	c_flag: cover property (o_receive_done_flag && ctl_r[3]);
	c_t2tx: cover property (o_tx_tick && txq_r == 2'h3 && t2c_r[3]);
	c_unmapped: cover property (i_avs_read && !o_avs_waitrequest && i_avs_address > 4'h5);
endmodule // sba_checker
`default_nettype wire

// >>> testbench/sba_top_test.sv
// testbench: self-checking bench for the baud select and address match block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sba_top_test;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, t1 = 0, t2x = 1, wq, txk, rxk, flg, irq, fd, b9, so;
	logic [3:0] ad = 4'h0;
	logic [7:0] rb, a, m;
	logic [31:0] wd = 32'h0, rdata, seed = 32'hbb13;
	logic [31:0] exp_q[$];
	logic [1:0] t1c = 2'h0;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	always #25 clk = ~clk;
	sba_top sba_top_i (.i_clk(clk), .i_rstn(rstn), .i_avs_address(ad), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wq), .i_t1_overflow(t1), .i_t2_count_pin(t1),
		.i_t2_external_input(t2x), .i_rx_frame_done(fd), .i_rx_byte(rb), .i_rx_bit9(b9),
		.i_rx_stop_ok(so), .o_tx_tick(txk), .o_rx_tick(rxk), .o_receive_done_flag(flg),
		.o_t2_ext_irq(irq));
	sba_node sba_node_i (.i_clk(clk), .o_done(fd), .o_byte(rb), .o_bit9(b9), .o_stop(so));
	// timer 1 interrupt off
	// timer 1 overflow every third clock, slower than the fixed modes on purpose
	// the same pulse feeds the timer 2 count pin for counter operation
	always @(posedge clk) begin
		t1c <= (t1c == 2'h2) ? 2'h0 : t1c + 2'h1;
		t1 <= (t1c == 2'h2);
	end
	// read watcher: oldest note is compared when the answer stands
	always @(posedge clk) if (rd && wq === 1'b0 && exp_q.size() > 0) `CHK(rdata, exp_q.pop_front())
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task complete_run;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one avalon access, held until waitrequest is sampled low
	// a hung wait is ended only by the bench timeout, which counts a mismatch
	task automatic bus(input logic w, input logic [3:0] x, input logic [31:0] d);
		@(posedge clk);
		{rd, wr, ad, wd} <= {!w, w, x, d};
		do @(posedge clk); while (wq !== 1'b0);
		{rd, wr} <= 2'b00;
	endtask
	task automatic rdx(input logic [3:0] x, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, x, 32'h0);
	endtask
	// clock count between the third and fourth tick after a change
	task automatic per(input logic tx, input int e);
		int n;
		for (int k = 0; k < 4; k++) begin
			n = 0;
			do begin @(posedge clk); n++; end while ((tx ? txk : rxk) !== 1'b1 && n < 9000);
		end
		`CHK(n, e)
	endtask
	// one received frame, the flag read back, then cleared by writing it zero
	task automatic fr(input logic [7:0] x, y, r, input logic [3:0] c, input logic n9, st);
		logic e;
		e = !c[3] || (((((r ^ x) & y) == 8'h0) || ((r & (x | y)) == (x | y))) && (c[1] ? n9 : st));
		bus(1'b1, sba_pkg::ADDR_SADR, {24'h0, x});
		bus(1'b1, sba_pkg::ADDR_SMSK, {24'h0, y});
		bus(1'b1, sba_pkg::ADDR_CTRL, {28'h0, c});
		sba_node_i.send(r, n9, st);
		repeat (4) @(posedge clk);
		`CHK(flg, e)
		rdx(sba_pkg::ADDR_CTRL, {27'h0, e, c});
		bus(1'b1, sba_pkg::ADDR_CTRL, {28'h0, c});
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rdx(sba_pkg::ADDR_SADR, 32'h0);
		rdx(sba_pkg::ADDR_SMSK, 32'h0);
		rdx(sba_pkg::ADDR_T1OV, 32'h0);
		bus(1'b1, 4'h9, 32'hff);
		rdx(4'h9, 32'h0);
		fr(8'h00, 8'h00, 8'h37, 4'hb, 1'b1, 1'b1);
		fr(8'hf1, 8'hfa, 8'hf0, 4'hb, 1'b1, 1'b1);
		fr(8'hf1, 8'hfa, 8'hfb, 4'hb, 1'b1, 1'b1);
		fr(8'hf2, 8'hfd, 8'hfb, 4'hb, 1'b1, 1'b1);
		fr(8'hf1, 8'hfa, 8'hf0, 4'hb, 1'b0, 1'b1);
		fr(8'hf1, 8'hfa, 8'hf0, 4'h9, 1'b1, 1'b0);
		fr(8'hf1, 8'hfa, 8'hf0, 4'h9, 1'b0, 1'b1);
		fr(8'hf1, 8'hfa, 8'h12, 4'h3, 1'b0, 1'b1);
		for (int j = 0; j < 8; j++) begin
			a = $random(seed);
			m = $random(seed);
			fr(a, m, j[0] ? 8'($random(seed)) : a ^ (8'($random(seed)) & ~m), 4'hb, 1'b1, 1'b1);
		end
		bus(1'b1, sba_pkg::ADDR_CTRL, 32'h0);
		per(1'b1, 12);
		per(1'b0, 12);
		bus(1'b1, sba_pkg::ADDR_CTRL, 32'h2);
		per(1'b0, 64);
		bus(1'b1, sba_pkg::ADDR_CTRL, 32'h6);
		per(1'b1, 32);
		bus(1'b1, sba_pkg::ADDR_CTRL, 32'h1);
		per(1'b1, 96);
		bus(1'b1, sba_pkg::ADDR_CTRL, 32'h7);
		per(1'b0, 48);
		// timer 2 stopped before its reload pair is touched, timer operation only
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h0);
		bus(1'b1, sba_pkg::ADDR_T2RL, 32'hffff);
		bus(1'b1, sba_pkg::ADDR_T2CT, 32'hffff);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h5);
		per(1'b0, 32);
		per(1'b1, 48);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h0);
		bus(1'b1, sba_pkg::ADDR_T2RL, 32'hfffe);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h9);
		per(1'b1, 64);
		per(1'b0, 48);
		rdx(sba_pkg::ADDR_T2CN, 32'h9);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h19);
		@(posedge clk) t2x <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b1)
		rdx(sba_pkg::ADDR_T2CN, 32'h39);
		per(1'b1, 64);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h19);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		// counter operation: one count pin fall every third clock, reload fffe
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'h0);
		bus(1'b1, sba_pkg::ADDR_T2CN, 32'hb);
		per(1'b1, 96);
		complete_run();
	end
endmodule // sba_top_test
bind sba_top sba_checker sba_checker_i (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_rx_frame_done(i_rx_frame_done),
	.i_rx_byte(i_rx_byte), .i_rx_bit9(i_rx_bit9), .i_rx_stop_ok(i_rx_stop_ok),
	.o_tx_tick(o_tx_tick), .o_rx_tick(o_rx_tick), .o_receive_done_flag(o_receive_done_flag));
`default_nettype wire
